// ===== pkg/bus_ctl_pkg.sv
// Constants for the processor-card backplane bus control block.
// Assumes a single 25 MHz system clock and synchronous active-high reset.
//
// Notes on behaviour
// [RL1] Maskable request waits for instruction end
// [RL2] Maskable sequence only when mask bit clear
// [RL3] Non-maskable sequence after instruction, mask ignored
// [RL4] Debug logic raises non-maskable for monitor
// [RL5] Address strobe driven while address valid
// [RL6] Float control high releases address lines
// [RL7] Float control high forces both strobes low
// [RL8] Float control leaves data drivers alone
// [RL9] Phase clocks derived from backplane master clock unless external clock selected
// [RL10] Selector picks internal or external clock; internal clock drives nothing, master clock used instead
// [RL11] Run lamp lit outside upper monitor 4K
// [RL12] Restart resets, then enters monitor
// [RL13] Abort ends routine, returns to monitor
// [RL14] Scope mode pulses on selected address
// [RL15] Stop mode halts at next instruction
// [RL16] Monitor-enable switch gates monitor firmware
// [RL17] Bus-released high on halt or wait
// [RL18] Slow memory ready low stretches phase two
// [RL19] Interrupt requests are active-low lines
package bus_ctl_pkg;

    // ***********************************************
    // Clocking
    // ***********************************************
    localparam int CLK_HZ = 25_000_000;
    localparam int INT_CLK_HZ = 1_000_000;
    // Half period of internal 1 MHz, in system cycles
    localparam int INT_HALF_CYC = CLK_HZ / (2 * INT_CLK_HZ);

    // ***********************************************
    // Address map
    // ***********************************************
    localparam int ADDR_W = 16;
    localparam logic [3:0] MON_TOP_NIBBLE = 4'hF;
    localparam logic [ADDR_W-1:0] RST_VECTOR = 16'hFFFE;
    localparam logic [ADDR_W-1:0] NMI_VECTOR = 16'hFFFC;
    localparam logic [ADDR_W-1:0] IRQ_VECTOR = 16'hFFF8;
    localparam logic [ADDR_W-1:0] MON_ENTRY = 16'hF000;
    localparam logic [ADDR_W-1:0] USER_ENTRY = 16'h0000;

    // ***********************************************
    // Register port
    // ***********************************************
    localparam int RA_W = 4;
    localparam logic [RA_W-1:0] REG_CTRL = 4'h0;
    localparam logic [RA_W-1:0] REG_STATUS = 4'h1;
    localparam logic [RA_W-1:0] REG_CLEAR = 4'h2;
    localparam logic [RA_W-1:0] REG_ENABLE = 4'h3;
    localparam logic [RA_W-1:0] REG_MATCH = 4'h4;
    localparam logic [RA_W-1:0] REG_PC = 4'h5;
    localparam logic [RA_W-1:0] REG_STATE = 4'h6;

    // Control fields
    localparam int CTRL_MASK_BIT = 0;
    localparam int CTRL_EXT_CLK = 1;
    localparam int CTRL_STOP_MODE = 2;
    localparam int CTRL_MON_EN = 3;
    localparam int CTRL_STEP = 4;
    localparam logic [7:0] CTRL_RESET = 8'h09;

    // Event bits
    localparam int EV_W = 5;
    localparam int EV_IRQ = 0;
    localparam int EV_NMI = 1;
    localparam int EV_MATCH = 2;
    localparam int EV_ABORT = 3;
    localparam int EV_RESTART = 4;

    // Instruction model: fetch, operand cycles, then end
    localparam logic [1:0] INSN_CYCLES = 2'h2;

    typedef enum logic [2:0] {
        ST_RESET = 3'b000,
        ST_FETCH = 3'b001,
        ST_EXEC = 3'b010,
        ST_VECTOR = 3'b011,
        ST_HALT = 3'b100
    } cpu_state_e;

endpackage : bus_ctl_pkg

// ===== rtl/cpu_backplane_bus_control.sv
// Processor-card bus control: interrupt acceptance, bus strobes,
// float control, phase clock generation, debug and front panel.
// Assumes backplane inputs are asynchronous to clk.
`timescale 1ns/100ps
`default_nettype none

module cpu_backplane_bus_control
    import bus_ctl_pkg::*;
#(
    parameter int SYNC_STAGES = 3
) (
    // System
    input wire logic clk,
    input wire logic reset,
    // Backplane inputs
    input wire logic irq_req_n,
    input wire logic nmi_req_n,
    input wire logic address_float_ctl,
    input wire logic slow_memory_ready,
    input wire logic backplane_master_clock,
    input wire logic ext_clock,
    input wire logic halt_req_n,
    // Front panel and switches
    input wire logic restart_btn,
    input wire logic abort_btn,
    // Address bus, two signals per line, then strobes, phase clocks and data enable
    output logic [ADDR_W-1:0] addr_out,
    output logic [ADDR_W-1:0] addr_oe_n,
    output logic valid_address_strobe,
    output logic bus_released,
    output logic phase1,
    output logic phase2,
    output logic data_oe_n,
    // Debug and lamp
    output logic scope_trigger,
    output logic run_lamp,
    output logic cpu_reset,
    // Register port
    input wire logic [RA_W-1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic irq_out
);

    // ***********************************************
    // Input synchronisers
    // ***********************************************
    localparam int NSYNC = 9;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] s1_q, s2_q, s3_q, in_q;
    assign raw_in = {abort_btn, restart_btn, halt_req_n, ext_clock,
                     backplane_master_clock, slow_memory_ready,
                     address_float_ctl, nmi_req_n, irq_req_n};

    // Reset to idle pin levels: no false panel edge after reset
    always_ff @(posedge clk) begin
        if (reset) begin
            s1_q <= 9'h04B;
            s2_q <= 9'h04B;
            s3_q <= 9'h04B;
            in_q <= 9'h04B;
        end else begin
            s1_q <= raw_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            in_q <= in_q;
            for (int i = 0; i < NSYNC; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    in_q[i] <= s3_q[i];
                end
            end
        end
    end

    logic irq_act, nmi_act, float_q, ready_q, mclk_q, eclk_q, halt_act;
    logic restart_q, abort_q;
    assign irq_act = ~in_q[0]; // RL19
    assign nmi_act = ~in_q[1]; // RL19
    assign float_q = in_q[2];
    assign ready_q = in_q[3];
    assign mclk_q = in_q[4];
    assign eclk_q = in_q[5];
    assign halt_act = ~in_q[6];
    assign restart_q = in_q[7];
    assign abort_q = in_q[8];

    // ***********************************************
    // Registers
    // ***********************************************
    logic [7:0] ctrl_q;
    logic [EV_W-1:0] status_q, enable_q, ev_set;
    logic [ADDR_W-1:0] match_q;
    logic step_pend_q;

    logic wr_ctrl, wr_clear, wr_enable, wr_match;
    assign wr_ctrl = reg_wr && reg_addr == REG_CTRL;
    assign wr_clear = reg_wr && reg_addr == REG_CLEAR;
    assign wr_enable = reg_wr && reg_addr == REG_ENABLE;
    assign wr_match = reg_wr && reg_addr == REG_MATCH;

    logic mask_bit, ext_sel, stop_mode, mon_en;
    assign mask_bit = ctrl_q[CTRL_MASK_BIT];
    assign ext_sel = ctrl_q[CTRL_EXT_CLK];
    assign stop_mode = ctrl_q[CTRL_STOP_MODE];
    assign mon_en = ctrl_q[CTRL_MON_EN];

    // ***********************************************
    // Clock source and phase generation
    // ***********************************************
    logic int_clk_q;
    logic [7:0] int_div_q;
    logic src_clk, src_prev_q, src_rise;
    assign src_clk = ext_sel ? eclk_q : int_clk_q; // RL10

    always_ff @(posedge clk) begin
        if (reset) begin
            int_div_q <= 8'h00;
            int_clk_q <= 1'b0;
        end else if (int_div_q == 8'(INT_HALF_CYC - 1)) begin
            int_div_q <= 8'h00;
            int_clk_q <= ~int_clk_q;
        end else begin
            int_div_q <= int_div_q + 8'h01;
        end
    end

    // Master clock edge advances the phase pair; external clock edge instead when selected
    logic mclk_prev_q, mclk_rise, tick;
    assign mclk_rise = mclk_q & ~mclk_prev_q;
    assign src_rise = src_clk & ~src_prev_q;
    assign tick = ext_sel ? src_rise : mclk_rise; // RL9

    // Phase sequence: 0 idle, 1 phase1, 2 gap, 3 phase2
    logic [1:0] ph_q;
    logic stretch, cycle_end;
    assign stretch = ph_q == 2'h3 && !ready_q; // RL18
    assign cycle_end = tick && ph_q == 2'h3 && !stretch;

    always_ff @(posedge clk) begin
        if (reset) begin
            mclk_prev_q <= 1'b0;
            src_prev_q <= 1'b0;
            ph_q <= 2'h0;
        end else begin
            mclk_prev_q <= mclk_q;
            src_prev_q <= src_clk;
            if (tick && !stretch) begin
                ph_q <= ph_q + 2'h1;
            end
        end
    end

    // ***********************************************
    // Instruction sequencer
    // ***********************************************
    cpu_state_e state_q, state_d;
    logic [ADDR_W-1:0] pc_q, pc_d;
    logic [1:0] icnt_q;
    logic in_monitor, insn_end, match_hit, nmi_pend_q, irq_take, nmi_take;
    logic halted;

    assign in_monitor = pc_q[ADDR_W-1 -: 4] == MON_TOP_NIBBLE;
    assign match_hit = pc_q == match_q && state_q != ST_RESET;
    assign insn_end = cycle_end && state_q == ST_EXEC
                      && icnt_q == INSN_CYCLES;
    // Interrupts sampled only at instruction boundary
    assign nmi_take = insn_end && (nmi_pend_q || nmi_act); // RL1 RL3
    assign irq_take = insn_end && irq_act && !mask_bit; // RL1 RL2
    // Wait state left by the waiting request; halt by the halt line
    assign halted = halt_act || state_q == ST_HALT;

    always_comb begin
        state_d = state_q;
        pc_d = pc_q;
        unique case (state_q)
            ST_RESET: begin
                if (cycle_end) begin
                    state_d = ST_FETCH;
                    pc_d = mon_en ? MON_ENTRY : USER_ENTRY; // RL12 RL16
                end
            end
            ST_FETCH: begin
                if (cycle_end) begin
                    state_d = halt_act ? ST_HALT : ST_EXEC;
                end
            end
            ST_EXEC: begin
                if (nmi_take) begin
                    state_d = ST_VECTOR;
                    pc_d = NMI_VECTOR; // RL3
                end else if (irq_take) begin
                    state_d = ST_VECTOR;
                    pc_d = IRQ_VECTOR; // RL2
                end else if (insn_end) begin
                    state_d = ST_FETCH;
                    pc_d = pc_q + 16'h0003;
                end
            end
            ST_VECTOR: begin
                if (cycle_end) begin
                    state_d = ST_FETCH;
                    pc_d = mon_en ? MON_ENTRY : USER_ENTRY; // RL16
                end
            end
            ST_HALT: begin
                if (!halt_act || irq_act) begin
                    state_d = ST_FETCH;
                end
            end
            default: begin
                state_d = ST_RESET;
            end
        endcase
    end

    // Restart and abort edges
    logic restart_prev_q, abort_prev_q, restart_ev, abort_ev;
    assign restart_ev = restart_q & ~restart_prev_q;
    assign abort_ev = abort_q & ~abort_prev_q;

    // Non-maskable source from debug: abort, step, stop-on-address
    logic dbg_nmi;
    assign dbg_nmi = abort_ev || (stop_mode && match_hit) // RL4 RL13 RL15
                     || (step_pend_q && insn_end);

    always_ff @(posedge clk) begin
        if (reset || restart_ev) begin // RL12
            state_q <= ST_RESET;
            pc_q <= RST_VECTOR;
            icnt_q <= 2'h0;
            nmi_pend_q <= 1'b0;
        end else begin
            state_q <= state_d;
            pc_q <= pc_d;
            if (state_q != ST_EXEC) begin
                icnt_q <= 2'h0;
            end else if (cycle_end) begin
                icnt_q <= icnt_q + 2'h1;
            end
            // Pending stays until taken; a new one wins over the take
            if (dbg_nmi) begin
                nmi_pend_q <= 1'b1;
            end else if (nmi_take) begin
                nmi_pend_q <= 1'b0;
            end
        end
    end

    // ***********************************************
    // Bus outputs
    // ***********************************************
    logic addr_valid;
    assign addr_valid = state_q != ST_RESET && !halted;

    always_ff @(posedge clk) begin
        if (reset) begin
            addr_out <= 16'h0000;
            addr_oe_n <= 16'hFFFF;
            valid_address_strobe <= 1'b0;
            bus_released <= 1'b0;
            phase1 <= 1'b0;
            phase2 <= 1'b0;
            data_oe_n <= 1'b1;
            scope_trigger <= 1'b0;
            run_lamp <= 1'b0;
            cpu_reset <= 1'b1;
            restart_prev_q <= 1'b0;
            abort_prev_q <= 1'b0;
        end else begin
            addr_out <= pc_q;
            // Address released on float or halt; data follows halt or the reset state, not float
            addr_oe_n <= (float_q || halted) ? 16'hFFFF : 16'h0000; // RL6 RL17
            valid_address_strobe <= addr_valid && !float_q; // RL5 RL7
            bus_released <= halted && !float_q; // RL7 RL17
            phase1 <= ph_q == 2'h1;
            phase2 <= ph_q == 2'h3; // RL9 RL18
            data_oe_n <= halted || state_q == ST_RESET; // RL8
            scope_trigger <= !stop_mode && match_hit && cycle_end; // RL14
            run_lamp <= addr_valid && !in_monitor; // RL11
            cpu_reset <= state_q == ST_RESET;
            restart_prev_q <= restart_q;
            abort_prev_q <= abort_q;
        end
    end

    // ***********************************************
    // Register port, events and interrupt
    // ***********************************************
    assign ev_set = {restart_ev, abort_ev, match_hit && cycle_end,
                     nmi_take, irq_take};

    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_q <= CTRL_RESET;
            enable_q <= 5'h00;
            match_q <= 16'h0000;
            status_q <= 5'h00;
            step_pend_q <= 1'b0;
            reg_rdata <= 16'h0000;
            irq_out <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= reg_wdata[7:0];
            end
            if (wr_enable) begin
                enable_q <= reg_wdata[EV_W-1:0];
            end
            if (wr_match) begin
                match_q <= reg_wdata;
            end
            // Set beats clear in the same cycle
            status_q <= (status_q & ~(wr_clear ? reg_wdata[EV_W-1:0]
                         : 5'h00)) | ev_set;
            // Single step request held until the next boundary
            if (wr_ctrl && reg_wdata[CTRL_STEP]) begin
                step_pend_q <= 1'b1;
            end else if (insn_end) begin
                step_pend_q <= 1'b0;
            end
            irq_out <= |(status_q & enable_q);
            reg_rdata <= 16'h0000;
            if (reg_rd) begin
                unique case (reg_addr)
                    REG_CTRL: reg_rdata <= {8'h00, ctrl_q};
                    REG_STATUS: reg_rdata <= {11'h000, status_q};
                    REG_ENABLE: reg_rdata <= {11'h000, enable_q};
                    REG_MATCH: reg_rdata <= match_q;
                    REG_PC: reg_rdata <= pc_q;
                    REG_STATE: reg_rdata <= {13'h0000, state_q};
                    default: reg_rdata <= 16'h0000;
                endcase
            end
        end
    end

endmodule : cpu_backplane_bus_control

`default_nettype wire

// ===== tb/bus_ctl_monitor.sv
// Checker for the processor-card bus control block.
// Assumes one clock domain and is bound in by the bench.
`timescale 1ns/100ps
`default_nettype none

module bus_ctl_monitor
    import bus_ctl_pkg::*;
(
    // System
    input wire logic clk,
    input wire logic reset,
    // Watched inputs
    input wire logic address_float_ctl,
    input wire logic slow_memory_ready,
    input wire logic reg_rd,
    // Watched outputs
    input wire logic [ADDR_W-1:0] addr_oe_n,
    input wire logic valid_address_strobe,
    input wire logic bus_released,
    input wire logic phase1,
    input wire logic phase2,
    input wire logic scope_trigger,
    input wire logic cpu_reset,
    input wire logic [15:0] reg_rdata
);
    // **********
    // Properties
    // **********
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // Seven samples: sync delay plus register stage, with margin
    sequence s_float_held;
        address_float_ctl [*7];
    endsequence
    sequence s_stalled_high;
        !slow_memory_ready [*7] ##0 phase2;
    endsequence

    property p_float_release;
        s_float_held |-> addr_oe_n == 16'hFFFF;
    endproperty
    property p_float_strobes;
        s_float_held |-> !valid_address_strobe && !bus_released;
    endproperty
    property p_strobe_drives;
        valid_address_strobe |-> addr_oe_n == 16'h0000;
    endproperty
    property p_released_floats;
        bus_released |-> addr_oe_n == 16'hFFFF;
    endproperty
    property p_no_overlap;
        !(phase1 && phase2);
    endproperty
    property p_scope_pulse;
        scope_trigger |=> !scope_trigger;
    endproperty
    property p_reset_entry;
        $fell(reset) |-> cpu_reset;
    endproperty
    property p_stall_hold;
        s_stalled_high ##1 !slow_memory_ready |-> phase2;
    endproperty
    property p_rdata_idle;
        !$past(reg_rd) |-> reg_rdata == 16'h0000;
    endproperty

    a_float_release: assert property (p_float_release)
        else $error("address lines driven while floated");
    a_float_strobes: assert property (p_float_strobes)
        else $error("strobes not low while floated");
    a_strobe_drives: assert property (p_strobe_drives)
        else $error("valid strobe without driven address");
    a_released_floats: assert property (p_released_floats)
        else $error("bus released but address driven");
    a_no_overlap: assert property (p_no_overlap)
        else $error("phase clocks overlap");
    a_scope_pulse: assert property (p_scope_pulse)
        else $error("scope trigger longer than one cycle");
    a_reset_entry: assert property (p_reset_entry)
        else $error("sequencer not in reset after reset");
    a_stall_hold: assert property (p_stall_hold)
        else $error("phase two dropped during stall");
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside its cycle");

endmodule : bus_ctl_monitor

`default_nettype wire

// ===== tb/backplane_model.sv
// Plug-in modules on the backplane: requesters, slow memory, clocks.
// Assumes the bench asks for each line by a want_ level.
`timescale 1ns/100ps
`default_nettype none

module backplane_model (
    // System
    input wire logic clk,
    input wire logic reset,
    // Requests from the bench
    input wire logic want_irq,
    input wire logic want_nmi,
    input wire logic want_float,
    input wire logic want_slow,
    input wire logic want_halt,
    // Backplane lines
    output logic irq_req_n = 1'b1,
    output logic nmi_req_n = 1'b1,
    output logic address_float_ctl = 1'b0,
    output logic slow_memory_ready = 1'b1,
    output logic halt_req_n = 1'b1,
    output logic backplane_master_clock = 1'b0,
    output logic ext_clock = 1'b0
);
    // **********
    // Line drivers
    // **********
    logic [2:0] div_q = 3'h0;

    // Clocks run free, also through reset
    always @(posedge clk) begin
        div_q <= div_q + 3'h1;
        backplane_master_clock <= div_q[1];
        ext_clock <= div_q[2];
    end

    // Released lines return to their idle level
    always @(posedge clk) begin
        irq_req_n <= !want_irq;
        nmi_req_n <= !want_nmi;
        address_float_ctl <= want_float;
        slow_memory_ready <= !want_slow;
        halt_req_n <= !want_halt;
    end

endmodule : backplane_model

`default_nettype wire

// ===== tb/test_cpu_backplane_bus_control.sv
// Self-checking bench for the processor-card bus control block.
// Assumes the backplane model drives all far-side lines.
`timescale 1ns/100ps
`default_nettype none

module test_cpu_backplane_bus_control
    import bus_ctl_pkg::*;
;
    // **********
    // Signals
    // **********
    logic clk = 1'b0, reset = 1'b1;
    logic want_irq = 1'b0, want_nmi = 1'b0, want_float = 1'b0;
    logic want_slow = 1'b0, want_halt = 1'b0;
    logic restart_btn = 1'b0, abort_btn = 1'b0;
    logic [RA_W-1:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, rv;
    logic reg_wr = 1'b0, reg_rd = 1'b0;
    wire logic irq_req_n, nmi_req_n, address_float_ctl, slow_memory_ready;
    wire logic halt_req_n, backplane_master_clock, ext_clock;
    logic [ADDR_W-1:0] addr_out, addr_oe_n;
    logic valid_address_strobe, bus_released, phase1, phase2, data_oe_n;
    logic scope_trigger, run_lamp, cpu_reset, irq_out;
    int failures = 0, n_checks = 0, i, n;

    always #20 clk = ~clk;

    backplane_model bp (.clk(clk), .reset(reset), .want_irq(want_irq),
        .want_nmi(want_nmi), .want_float(want_float), .want_slow(want_slow),
        .want_halt(want_halt), .irq_req_n(irq_req_n), .nmi_req_n(nmi_req_n),
        .address_float_ctl(address_float_ctl),
        .slow_memory_ready(slow_memory_ready), .halt_req_n(halt_req_n),
        .backplane_master_clock(backplane_master_clock),
        .ext_clock(ext_clock));

    cpu_backplane_bus_control dut (.clk(clk), .reset(reset),
        .irq_req_n(irq_req_n), .nmi_req_n(nmi_req_n),
        .address_float_ctl(address_float_ctl),
        .slow_memory_ready(slow_memory_ready),
        .backplane_master_clock(backplane_master_clock),
        .ext_clock(ext_clock), .halt_req_n(halt_req_n),
        .restart_btn(restart_btn), .abort_btn(abort_btn),
        .addr_out(addr_out), .addr_oe_n(addr_oe_n),
        .valid_address_strobe(valid_address_strobe),
        .bus_released(bus_released), .phase1(phase1), .phase2(phase2),
        .data_oe_n(data_oe_n), .scope_trigger(scope_trigger),
        .run_lamp(run_lamp), .cpu_reset(cpu_reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq_out(irq_out));

    // **********
    // Helpers
    // **********
    task wrap_up;
        if (failures == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrap_up

    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task late(input string nm);
        if (i >= 2000) begin
            failures++;
            $display("mismatch %s expected done seen timeout", nm);
            wrap_up();
        end
    endtask : late

    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Data stands only in the cycle after the strobe
    task rd(input logic [3:0] a);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask : rd

    task poll(input logic [3:0] a, input logic [15:0] m,
              input logic [15:0] w, input string nm);
        for (i = 0; i < 2000; i++) begin
            rd(a);
            if ((rv & m) === w) break;
        end
        late(nm);
        chk(nm, w, rv & m);
    endtask : poll

    // Four cycles so the synchroniser sees a settled level
    task restart;
        @(posedge clk);
        restart_btn <= 1'b1;
        repeat (4) @(posedge clk);
        restart_btn <= 1'b0;
    endtask : restart

    // **********
    // Scenarios
    // **********
    task t_regs;
        rd(REG_CTRL);
        chk("ctrl reset", 16'h0009, rv);
        rd(4'hF);
        chk("unmapped", 16'h0000, rv);
        wr(REG_STATUS, 16'h001F);
        rd(REG_STATUS);
        chk("status read-only", 16'h0000, rv);
        wr(REG_ENABLE, 16'h001F);
        rd(REG_ENABLE);
        chk("enable", 16'h001F, rv);
    endtask : t_regs

    task t_interrupts;
        @(posedge clk);
        want_irq <= 1'b1;
        repeat (80) @(posedge clk);
        rd(REG_STATUS);
        chk("irq masked", 16'h0000, rv & 16'h0001);
        @(posedge clk);
        want_nmi <= 1'b1;
        poll(REG_STATUS, 16'h0002, 16'h0002, "nmi taken");
        chk("irq_out set", 16'h0001, irq_out);
        @(posedge clk);
        want_nmi <= 1'b0;
        wr(REG_CTRL, 16'h0008);
        poll(REG_STATUS, 16'h0001, 16'h0001, "irq taken");
        @(posedge clk);
        want_irq <= 1'b0;
        wr(REG_ENABLE, 16'h0000);
        repeat (2) @(posedge clk);
        #1 chk("irq_out disabled", 16'h0000, irq_out);
        repeat (20) @(posedge clk);
        wr(REG_CLEAR, 16'h001F);
        rd(REG_STATUS);
        chk("status cleared", 16'h0000, rv & 16'h0003);
        wr(REG_ENABLE, 16'h001F);
    endtask : t_interrupts

    task t_panel;
        @(posedge clk);
        abort_btn <= 1'b1;
        repeat (4) @(posedge clk);
        abort_btn <= 1'b0;
        poll(REG_STATUS, 16'h0008, 16'h0008, "abort");
        poll(REG_PC, 16'hFFFF, 16'hF000, "abort to monitor");
        chk("lamp in monitor", 16'h0000, run_lamp);
        wr(REG_CTRL, 16'h0001);
        restart();
        poll(REG_STATUS, 16'h0010, 16'h0010, "restart");
        poll(REG_PC, 16'hF000, 16'h0000, "monitor off");
        chk("user addr", 16'h0000, addr_out & 16'hF000);
        for (i = 0; i < 2000 && run_lamp !== 1'b1; i++) @(posedge clk);
        late("lamp");
        chk("lamp in user", 16'h0001, run_lamp);
        wr(REG_CTRL, 16'h0009);
        restart();
        poll(REG_PC, 16'hFFFF, 16'hF000, "monitor entry");
    endtask : t_panel

    // Match three instructions ahead of the running address
    task t_debug;
        rd(REG_PC);
        wr(REG_MATCH, rv + 16'h0009);
        for (i = 0; i < 2000 && scope_trigger !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        late("scope trigger");
        wr(REG_CLEAR, 16'h001F);
        wr(REG_CTRL, 16'h0019);
        poll(REG_STATUS, 16'h0002, 16'h0002, "step nmi");
        poll(REG_PC, 16'hFFFF, 16'hF000, "step to monitor");
        wr(REG_MATCH, 16'hF009);
        wr(REG_CLEAR, 16'h001F);
        wr(REG_CTRL, 16'h000D);
        poll(REG_STATUS, 16'h0006, 16'h0006, "stop nmi");
        poll(REG_PC, 16'hFFFF, 16'hF000, "stop to monitor");
        wr(REG_CTRL, 16'h0009);
        restart();
        poll(REG_PC, 16'hFFFF, 16'hF000, "restart entry");
    endtask : t_debug

    task t_bus;
        @(posedge clk);
        want_float <= 1'b1;
        repeat (10) @(posedge clk);
        #1 chk("float addr", 16'hFFFF, addr_oe_n);
        chk("float strobes", 16'h0000,
            {valid_address_strobe, bus_released});
        chk("float data", 16'h0000, data_oe_n);
        want_float <= 1'b0;
        want_halt <= 1'b1;
        for (i = 0; i < 2000 && bus_released !== 1'b1; i++) @(posedge clk);
        late("halt");
        #1 chk("halt addr", 16'hFFFF, addr_oe_n);
        want_halt <= 1'b0;
        want_slow <= 1'b1;
        repeat (30) @(posedge clk);
        #1 chk("stall phase2", 16'h0001, phase2);
        want_slow <= 1'b0;
    endtask : t_bus

    task t_clocks;
        logic p;
        for (int c = 0; c < 2; c++) begin
            wr(REG_CTRL, c == 0 ? 16'h0009 : 16'h000B);
            n = 0;
            p = phase1;
            repeat (400) begin
                @(posedge clk);
                #1 if (phase1 === 1'b1 && p === 1'b0) n++;
                p = phase1;
            end
            chk("phase1 runs", 16'h0001, {15'h0, n > 0});
        end
    endtask : t_clocks

    initial begin
        repeat (15) @(posedge clk);
        #1 chk("reset state", 16'h0001, cpu_reset);
        chk("reset addr", 16'hFFFF, addr_oe_n);
        @(posedge clk);
        reset <= 1'b0;
        t_regs();
        t_interrupts();
        t_panel();
        t_debug();
        t_bus();
        t_clocks();
        wrap_up();
    end

endmodule : test_cpu_backplane_bus_control

bind cpu_backplane_bus_control bus_ctl_monitor mon (.clk(clk),
    .reset(reset), .address_float_ctl(address_float_ctl),
    .slow_memory_ready(slow_memory_ready), .reg_rd(reg_rd),
    .addr_oe_n(addr_oe_n), .valid_address_strobe(valid_address_strobe),
    .bus_released(bus_released), .phase1(phase1), .phase2(phase2),
    .scope_trigger(scope_trigger), .cpu_reset(cpu_reset),
    .reg_rdata(reg_rdata));

`default_nettype wire
